// ### verilog/cnd_pkg.sv
// constants and types of the condition code evaluator
// assumes one clock and an AXI4-Lite master with 32-bit data
package cnd_pkg;

  // register byte offsets
  localparam logic [7:0] CND_OFS_CTRL    = 8'h00;
  localparam logic [7:0] CND_OFS_SUBCODE = 8'h04;
  localparam logic [7:0] CND_OFS_FLAGS   = 8'h08;
  localparam logic [7:0] CND_OFS_STATUS  = 8'h0C;
  localparam logic [7:0] CND_OFS_EVALS   = 8'h10;
  localparam logic [7:0] CND_OFS_TRUES   = 8'h14;

  // control and status fields
  localparam int CND_CTRL_EN_BIT  = 0;
  localparam int CND_CTRL_GO_BIT  = 1;
  localparam int CND_ST_LAST_BIT  = 0;
  localparam int CND_ST_SW_BIT    = 1;
  localparam int CND_ST_DONE_BIT  = 2;
  localparam int CND_ST_SUB_LSB   = 4;

  // values after reset
  localparam logic        CND_CTRL_EN_RST = 1'b1;
  localparam logic [3:0]  CND_SUBCODE_RST = 4'h0;
  localparam logic [31:0] CND_WORD_RST    = 32'h0000_0000;

  // flag positions inside the processor flags word
  localparam int CND_POS_CARRY    = 0;
  localparam int CND_POS_PARITY   = 2;
  localparam int CND_POS_ZERO     = 6;
  localparam int CND_POS_SIGN     = 7;
  localparam int CND_POS_OVERFLOW = 11;

  // bus answers
  localparam logic [1:0] CND_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CND_RESP_SLVERR = 2'h2;

  // condition subcodes, primary names
  typedef enum logic [3:0] {
    CND_OVERFLOW = 4'h0, CND_NO_OVERFLOW = 4'h1,
    CND_BELOW    = 4'h2, CND_NOT_BELOW   = 4'h3,
    CND_EQUAL    = 4'h4, CND_NOT_EQUAL   = 4'h5,
    CND_BELOW_EQ = 4'h6, CND_ABOVE       = 4'h7,
    CND_SIGN     = 4'h8, CND_NO_SIGN     = 4'h9,
    CND_PARITY   = 4'hA, CND_NO_PARITY   = 4'hB,
    CND_LESS     = 4'hC, CND_GREATER_EQ  = 4'hD,
    CND_LESS_EQ  = 4'hE, CND_GREATER     = 4'hF
  } cnd_code_t;

  // alternate names share the code of the same test
  localparam cnd_code_t CND_NOT_ABOVE_EQ   = CND_BELOW;
  localparam cnd_code_t CND_ABOVE_EQ       = CND_NOT_BELOW;
  localparam cnd_code_t CND_ZERO           = CND_EQUAL;
  localparam cnd_code_t CND_NOT_ZERO       = CND_NOT_EQUAL;
  localparam cnd_code_t CND_NOT_ABOVE      = CND_BELOW_EQ;
  localparam cnd_code_t CND_NOT_BELOW_EQ   = CND_ABOVE;
  localparam cnd_code_t CND_PARITY_EVEN    = CND_PARITY;
  localparam cnd_code_t CND_PARITY_ODD     = CND_NO_PARITY;
  localparam cnd_code_t CND_NOT_GREATER_EQ = CND_LESS;
  localparam cnd_code_t CND_NOT_LESS       = CND_GREATER_EQ;
  localparam cnd_code_t CND_NOT_GREATER    = CND_LESS_EQ;
  localparam cnd_code_t CND_NOT_LESS_EQ    = CND_GREATER;

  // consumer of the result
  typedef enum logic [1:0] {
    CND_KIND_JUMP       = 2'h0,
    CND_KIND_INT_MOVE   = 2'h1,
    CND_KIND_FLOAT_MOVE = 2'h2,
    CND_KIND_SET_BYTE   = 2'h3
  } cnd_kind_t;

  // the five tested status flags
  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic parity_flag;
    logic carry_flag;
  } cnd_flags_t;

  // request from decode and answer to execute
  typedef struct packed {
    cnd_kind_t   kind;
    cnd_code_t   subcode;
    logic [31:0] flags_word;
  } cnd_req_t;

  typedef struct packed {
    cnd_kind_t  kind;
    logic       taken;
    logic [7:0] set_byte;
  } cnd_res_t;

endpackage

// ### verilog/cnd_top.sv
// condition code evaluator with its AXI4-Lite register file
// assumes decode inputs are on clk and the bus master follows AXI4-Lite
`timescale 1ns/1ps

// Function
// - subcode 0000 true when overflow set, 0001 when overflow clear
// - subcode 0010 true when carry set, 0011 when carry clear
// - subcode 0100 true when zero set, 0101 when zero clear
// - 0110 true if carry or zero set, 0111 only if both clear
// - subcode 1000 true when sign set, 1001 when sign clear
// - subcode 1010 true on parity set, 1011 on parity clear
// - 1100 true when sign differs from overflow, 1101 when equal
// - 1110 true on zero or sign/overflow differ, 1111 its inverse
// - four-bit subcode selects the test for jumps, moves and set-byte
// - alternate names of one test share one subcode and result
// - above and below use carry, ordering unsigned operands
// - greater and less use sign and overflow, ordering signed operands
// - only carry, overflow, sign, zero and parity bits are read
module cnd_top
  import cnd_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // decode side
  input  wire logic        dec_valid,
  input  wire cnd_req_t    dec_req,
  // execute side
  output logic             res_valid,
  output cnd_res_t         res
);

  // evaluate one subcode against the five flags
  function automatic logic cnd_eval(input cnd_code_t code, input cnd_flags_t f);
    logic lt;
    lt = f.sign_flag ^ f.overflow_flag;
    case (code)
      CND_OVERFLOW:    cnd_eval = f.overflow_flag;
      CND_NO_OVERFLOW: cnd_eval = ~f.overflow_flag;
      CND_BELOW:       cnd_eval = f.carry_flag;
      CND_NOT_BELOW:   cnd_eval = ~f.carry_flag;
      CND_EQUAL:       cnd_eval = f.zero_flag;
      CND_NOT_EQUAL:   cnd_eval = ~f.zero_flag;
      CND_BELOW_EQ:    cnd_eval = f.carry_flag | f.zero_flag;
      CND_ABOVE:       cnd_eval = ~(f.carry_flag | f.zero_flag);
      CND_SIGN:        cnd_eval = f.sign_flag;
      CND_NO_SIGN:     cnd_eval = ~f.sign_flag;
      CND_PARITY:      cnd_eval = f.parity_flag;
      CND_NO_PARITY:   cnd_eval = ~f.parity_flag;
      CND_LESS:        cnd_eval = lt;
      CND_GREATER_EQ:  cnd_eval = ~lt;
      CND_LESS_EQ:     cnd_eval = lt | f.zero_flag;
      CND_GREATER:     cnd_eval = ~(lt | f.zero_flag);
      default:         cnd_eval = 1'b0;
    endcase
  endfunction

  // pull the tested flags out of a full flags word, ignore the rest
  function automatic cnd_flags_t cnd_pick(input logic [31:0] w);
    cnd_flags_t f;
    f.overflow_flag = w[CND_POS_OVERFLOW];
    f.sign_flag     = w[CND_POS_SIGN];
    f.zero_flag     = w[CND_POS_ZERO];
    f.parity_flag   = w[CND_POS_PARITY];
    f.carry_flag    = w[CND_POS_CARRY];
    cnd_pick = f;
  endfunction

  // merge a write under byte enables
  function automatic logic [31:0] cnd_strb(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    cnd_strb = v;
  endfunction

  // address decode shared by both channels
  function automatic logic cnd_hit(input logic [7:0] a);
    cnd_hit = (a == CND_OFS_CTRL)   || (a == CND_OFS_SUBCODE) ||
              (a == CND_OFS_FLAGS)  || (a == CND_OFS_STATUS)  ||
              (a == CND_OFS_EVALS)  || (a == CND_OFS_TRUES);
  endfunction

  // bus channel state
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  // register file state
  logic        ctrl_en_ff;
  cnd_code_t   sw_code_ff;
  logic [31:0] sw_word_ff;
  logic        sw_taken_ff;
  logic        sw_done_ff;
  cnd_code_t   last_code_ff;
  logic [31:0] evals_ff;
  logic [31:0] trues_ff;
  logic        res_valid_ff;
  cnd_res_t    res_ff;

  // handshakes and decoded writes
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        ar_take;
  logic        nxt_aw_held;
  logic        nxt_w_held;
  logic        nxt_bvalid;
  logic        nxt_rvalid;
  logic        wr_ctrl;
  logic        wr_sub;
  logic        wr_word;
  logic        wr_status;
  logic        wr_evals;
  logic        sw_go;
  logic        eval_fire;
  logic        eval_taken;
  logic [31:0] rd_data;

  assign aw_take   = s_axi_awvalid & awready_ff;
  assign w_take    = s_axi_wvalid & wready_ff;
  // both halves latched first, so address and data may come in any order
  assign wr_fire   = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign ar_take   = s_axi_arvalid & arready_ff;
  assign nxt_aw_held = ~wr_fire & (aw_held_ff | aw_take);
  assign nxt_w_held  = ~wr_fire & (w_held_ff | w_take);
  assign nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready);
  assign nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready);

  // write strobes per register
  assign wr_ctrl   = wr_fire && awaddr_ff == CND_OFS_CTRL;
  assign wr_sub    = wr_fire && awaddr_ff == CND_OFS_SUBCODE;
  assign wr_word   = wr_fire && awaddr_ff == CND_OFS_FLAGS;
  assign wr_status = wr_fire && awaddr_ff == CND_OFS_STATUS;
  assign wr_evals  = wr_fire && awaddr_ff == CND_OFS_EVALS;
  assign sw_go     = wr_ctrl && wstrb_ff[0] && wdata_ff[CND_CTRL_GO_BIT];

  // pipeline evaluation from current inputs, gated by the enable register ctrl_en_ff
  assign eval_fire  = dec_valid & ctrl_en_ff;
  assign eval_taken = cnd_eval(dec_req.subcode, cnd_pick(dec_req.flags_word));

  // write channel; readies drop while a write waits for its response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= CND_RESP_OKAY;
    end else if (clk_en) begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_ff <= cnd_hit(awaddr_ff) ? CND_RESP_OKAY : CND_RESP_SLVERR;
      end
    end
  end

  // read mux; unmapped words read zero with an error answer
  always_comb begin
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      CND_OFS_CTRL:    rd_data[CND_CTRL_EN_BIT] = ctrl_en_ff;
      CND_OFS_SUBCODE: rd_data[3:0] = sw_code_ff;
      CND_OFS_FLAGS:   rd_data = sw_word_ff;
      CND_OFS_STATUS: begin
        rd_data[CND_ST_LAST_BIT] = res_ff.taken;
        rd_data[CND_ST_SW_BIT]   = sw_taken_ff;
        rd_data[CND_ST_DONE_BIT] = sw_done_ff;
        rd_data[CND_ST_SUB_LSB +: 4] = last_code_ff;
      end
      CND_OFS_EVALS:   rd_data = evals_ff;
      CND_OFS_TRUES:   rd_data = trues_ff;
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // read channel; one read at a time, answer one cycle after address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= CND_RESP_OKAY;
    end else if (clk_en) begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_data;
        rresp_ff <= cnd_hit(s_axi_araddr) ? CND_RESP_OKAY : CND_RESP_SLVERR;
      end
    end
  end

  // software controls; the go bit is a self-clearing action
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_ff <= CND_CTRL_EN_RST;
      sw_code_ff <= cnd_code_t'(CND_SUBCODE_RST);
      sw_word_ff <= CND_WORD_RST;
    end else if (clk_en) begin
      if (wr_ctrl && wstrb_ff[0]) begin
        ctrl_en_ff <= wdata_ff[CND_CTRL_EN_BIT];
      end
      if (wr_sub && wstrb_ff[0]) begin
        sw_code_ff <= cnd_code_t'(wdata_ff[3:0]);
      end
      if (wr_word) begin
        sw_word_ff <= cnd_strb(sw_word_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  // software test path; a new result wins over a done clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_taken_ff <= 1'b0;
      sw_done_ff  <= 1'b0;
    end else if (clk_en) begin
      if (sw_go) begin
        sw_taken_ff <= cnd_eval(sw_code_ff, cnd_pick(sw_word_ff));
        sw_done_ff  <= 1'b1;
      end else if (wr_status && wstrb_ff[0] && wdata_ff[CND_ST_DONE_BIT]) begin
        sw_done_ff <= 1'b0;
      end
    end
  end

  // registered result for the consumer; kind, taken and set byte load only on eval_fire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_ff <= 1'b0;
      res_ff       <= '0;
      last_code_ff <= cnd_code_t'(CND_SUBCODE_RST);
    end else if (clk_en) begin
      res_valid_ff <= eval_fire;
      if (eval_fire) begin
        res_ff.kind     <= dec_req.kind;
        res_ff.taken    <= eval_taken;
        res_ff.set_byte <= {7'h00, eval_taken};
        last_code_ff    <= dec_req.subcode;
      end
    end
  end

  // activity counters; a write to the first clears both
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evals_ff <= CND_WORD_RST;
      trues_ff <= CND_WORD_RST;
    end else if (clk_en) begin
      evals_ff <= (wr_evals ? CND_WORD_RST : evals_ff) + {31'h0, eval_fire};
      trues_ff <= (wr_evals ? CND_WORD_RST : trues_ff) + {31'h0, eval_fire & eval_taken};
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign res_valid     = res_valid_ff;
  assign res           = res_ff;

  // checks on the evaluated result, one cycle after the request
  chk_overflow_pair: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode[3:1] == 3'b000 |=>
      res_ff.taken == ($past(dec_req.flags_word[CND_POS_OVERFLOW]) ^ $past(dec_req.subcode[0])))
    else $error("overflow test result wrong");

  chk_carry_pair: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode[3:1] == 3'b001 |=>
      res_ff.taken == ($past(dec_req.flags_word[CND_POS_CARRY]) ^ $past(dec_req.subcode[0])))
    else $error("carry test result wrong");

  chk_zero_pair: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode[3:1] == 3'b010 |=>
      res_ff.taken == ($past(dec_req.flags_word[CND_POS_ZERO]) ^ $past(dec_req.subcode[0])))
    else $error("zero test result wrong");

  chk_unsigned_above: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode == CND_ABOVE &&
    (dec_req.flags_word[CND_POS_CARRY] || dec_req.flags_word[CND_POS_ZERO]) |=>
      !res_ff.taken && res_valid_ff)
    else $error("above true with carry or zero set");

  chk_sign_pair: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode[3:1] == 3'b100 |=>
      res_ff.taken == ($past(dec_req.flags_word[CND_POS_SIGN]) ^ $past(dec_req.subcode[0])))
    else $error("sign test result wrong");

  chk_parity_pair: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode[3:1] == 3'b101 |=>
      res_ff.taken == ($past(dec_req.flags_word[CND_POS_PARITY]) ^ $past(dec_req.subcode[0])))
    else $error("parity test result wrong");

  chk_signed_less: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode == CND_LESS |=>
      res_ff.taken == ($past(dec_req.flags_word[CND_POS_SIGN]) !=
                       $past(dec_req.flags_word[CND_POS_OVERFLOW])))
    else $error("less result wrong");

  chk_signed_greater: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire && dec_req.subcode == CND_GREATER && dec_req.flags_word[CND_POS_ZERO]
      |=> !res_ff.taken)
    else $error("greater true with zero set");

  chk_kind_follow: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && eval_fire |=> res_valid_ff && res_ff.kind == $past(dec_req.kind) &&
      res_ff.set_byte == {7'h00, res_ff.taken})
    else $error("result kind or set byte wrong");

  chk_result_idle: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !eval_fire |=> !res_valid_ff ##1 (!$past(clk_en) || $stable(evals_ff) ||
      $past(eval_fire) || $past(wr_evals)))
    else $error("result valid without request");

endmodule

// ### testbench/cnd_pipe_model.sv
// model of the decode and execute pipeline on the far side of the evaluator
// assumes clk and rst_n are shared with the evaluator; the bench calls its tasks
`timescale 1ns/1ps
module cnd_pipe_model
  import cnd_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // request toward the evaluator
  output logic          dec_valid,
  output cnd_req_t      dec_req,
  // answer from the evaluator
  input  wire logic     res_valid,
  input  wire cnd_res_t res
);
  cnd_res_t got_q[$];

  // quiet request lines from time zero
  initial begin
    dec_valid = 1'b0;
    dec_req   = '0;
  end

  // one request per edge; every consumer kind sends the same four-bit subcode
  task automatic issue(input cnd_kind_t k, input cnd_code_t c, input logic [31:0] w);
    @(posedge clk);
    dec_valid <= 1'b1;
    dec_req   <= '{kind: k, subcode: c, flags_word: w};
  endtask

  // drop the strobe; flip the word so stale flags never look like a request
  task automatic idle();
    @(posedge clk);
    dec_valid          <= 1'b0;
    dec_req.flags_word <= ~dec_req.flags_word;
  endtask

  // collect answers; a pulse longer than one cycle shows up as extra entries
  always @(posedge clk) begin
    if (rst_n && res_valid) begin
      got_q.push_back(res);
    end
  end
endmodule

// ### testbench/test_condition_code_evaluator.sv
// self-checking bench of the condition code evaluator over its bus and pipeline
// assumes the package and the pipeline model are compiled before this file
`timescale 1ns/1ps
module test_condition_code_evaluator;
  import cnd_pkg::*;
  localparam int LIMIT = 3000;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        clk_en  = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, dec_valid, res_valid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  cnd_req_t    dec_req;
  cnd_res_t    res;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  cnd_top uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dec_valid(dec_valid), .dec_req(dec_req), .res_valid(res_valid), .res(res));

  cnd_pipe_model pipe (.clk(clk), .rst_n(rst_n), .dec_valid(dec_valid), .dec_req(dec_req),
    .res_valid(res_valid), .res(res));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // write: both halves offered together, each dropped once taken
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // reference answer worked out from the flag table
  function automatic logic exp_taken(input logic [3:0] c, input cnd_flags_t f);
    logic t;
    case (c[3:1])
      3'h0: t = f.overflow_flag;
      3'h1: t = f.carry_flag;
      3'h2: t = f.zero_flag;
      3'h3: t = f.carry_flag | f.zero_flag;
      3'h4: t = f.sign_flag;
      3'h5: t = f.parity_flag;
      3'h6: t = f.sign_flag ^ f.overflow_flag;
      default: t = (f.sign_flag ^ f.overflow_flag) | f.zero_flag;
    endcase
    return t ^ c[0];
  endfunction

  // noise around the five flags proves the other bits are ignored
  function automatic logic [31:0] mk_word(input cnd_flags_t f, input logic [31:0] noise);
    logic [31:0] w;
    w = noise;
    w[CND_POS_CARRY]    = f.carry_flag;
    w[CND_POS_PARITY]   = f.parity_flag;
    w[CND_POS_ZERO]     = f.zero_flag;
    w[CND_POS_SIGN]     = f.sign_flag;
    w[CND_POS_OVERFLOW] = f.overflow_flag;
    return w;
  endfunction

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    cnd_flags_t  fl;
    cnd_res_t    exp_q[$];
    logic [31:0] d;
    logic [1:0]  r;
    logic        t;
    int          trues;
    trues = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and unmapped places
    bus_rd(CND_OFS_CTRL, d, r);
    check("ctrl reset", d, {31'h0, CND_CTRL_EN_RST});
    check("ctrl read resp", {30'h0, r}, {30'h0, CND_RESP_OKAY});
    bus_rd(CND_OFS_SUBCODE, d, r);
    check("subcode reset", d, {28'h0, CND_SUBCODE_RST});
    bus_rd(8'h20, d, r);
    check("unmapped read resp", {30'h0, r}, {30'h0, CND_RESP_SLVERR});
    bus_wr(8'h24, 32'h0000_00FF, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, CND_RESP_SLVERR});
    bus_wr(CND_OFS_EVALS, 32'h0, r);
    check("clear write resp", {30'h0, r}, {30'h0, CND_RESP_OKAY});
    // every subcode against every flag mix, back to back, all consumer kinds
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 32; f++) begin
        fl = cnd_flags_t'(f[4:0]);
        t  = exp_taken(c[3:0], fl);
        trues += t;
        exp_q.push_back('{kind: cnd_kind_t'(f[1:0]), taken: t, set_byte: {7'h00, t}});
        pipe.issue(cnd_kind_t'(f[1:0]), cnd_code_t'(c[3:0]),
                   mk_word(fl, f[0] ? 32'h5A5A_A5A5 : 32'hA5A5_5A5A));
      end
    end
    exp_q.push_back('{kind: CND_KIND_SET_BYTE, taken: 1'b1, set_byte: 8'h01});
    pipe.issue(CND_KIND_SET_BYTE, CND_NOT_GREATER, 32'h1 << CND_POS_ZERO);
    pipe.idle();
    repeat (3) @(posedge clk);
    check("answer count", pipe.got_q.size(), exp_q.size());
    foreach (exp_q[i]) check("result", {21'h0, pipe.got_q[i]}, {21'h0, exp_q[i]});
    bus_rd(CND_OFS_EVALS, d, r);
    check("eval count", d, 32'd513);
    bus_rd(CND_OFS_TRUES, d, r);
    check("true count", d, trues + 1);
    bus_rd(CND_OFS_STATUS, d, r);
    check("last pipeline", {27'h0, d[7:4], d[0]}, {27'h0, 4'hE, 1'b1});
    // software evaluation with zero set, then sign equal to overflow
    bus_wr(CND_OFS_FLAGS, 32'hFFFF_F000 | (32'h1 << CND_POS_ZERO), r);
    bus_wr(CND_OFS_SUBCODE, {28'h0, CND_LESS_EQ}, r);
    bus_wr(CND_OFS_CTRL, 32'h0000_0003, r);
    bus_rd(CND_OFS_STATUS, d, r);
    check("sw true", {30'h0, d[2:1]}, 32'h3);
    bus_wr(CND_OFS_FLAGS, (32'h1 << CND_POS_SIGN) | (32'h1 << CND_POS_OVERFLOW), r);
    bus_wr(CND_OFS_CTRL, 32'h0000_0003, r);
    bus_rd(CND_OFS_STATUS, d, r);
    check("sw false", {30'h0, d[2:1]}, 32'h2);
    // done is write-one-to-clear; the flags word honours byte lanes
    bus_wr(CND_OFS_STATUS, 32'h0000_0004, r);
    bus_rd(CND_OFS_STATUS, d, r);
    check("done clear", {31'h0, d[2]}, 32'h0);
    wstrb <= 4'h1;
    bus_wr(CND_OFS_FLAGS, 32'hFFFF_FF41, r);
    wstrb <= 4'hF;
    bus_rd(CND_OFS_FLAGS, d, r);
    check("flags lanes", d, 32'h0000_0841);
    // disabled evaluator ignores the pipeline
    bus_wr(CND_OFS_CTRL, 32'h0, r);
    pipe.issue(CND_KIND_JUMP, CND_NO_OVERFLOW, 32'h0);
    pipe.idle();
    repeat (3) @(posedge clk);
    check("disabled answers", pipe.got_q.size(), exp_q.size());
    bus_rd(CND_OFS_EVALS, d, r);
    check("disabled count", d, 32'd513);
    // frozen clock enable: a request offered during the freeze is not taken
    bus_wr(CND_OFS_CTRL, 32'h0000_0001, r);
    clk_en <= 1'b0;
    pipe.issue(CND_KIND_JUMP, CND_OVERFLOW, 32'h0);
    pipe.idle();
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    check("frozen answers", pipe.got_q.size(), exp_q.size());
    bus_rd(CND_OFS_EVALS, d, r);
    check("frozen count", d, 32'd513);
    wrap_up();
  end
endmodule
